// *** verification/tccpa_pin_model.sv ***
// Purpose: pin-side partner model of the timer capture block
// Assumes: bench calls its tasks just after a rising edge
// Notes: undriven compare pins read back a level flipping each cycle
`timescale 1ns/1ps
`default_nettype none
module tccpa_pin_model (
    input wire logic sys_clk,
    input wire logic [4:0] port_pin_o,
    input wire logic [4:0] port_pin_oe,
    output logic [4:0] port_pin_i,
    output logic [2:0] cap_pin,
    output logic acc_in_pin,
    output logic aux_clk_pin
);
    logic [4:0] ext_r;
    // idle levels; aux clock stands still
    initial begin
        cap_pin = 3'h0;
        acc_in_pin = 1'b0;
        aux_clk_pin = 1'b0;
        ext_r = 5'h00;
    end
    // released pins never hold the last value
    always @(posedge sys_clk) begin
        ext_r <= ~ext_r;
    end
    assign port_pin_i = (port_pin_oe & port_pin_o) | (~port_pin_oe & ext_r);
    // levels on capture and accumulator pins
    task automatic set_pins(input logic [2:0] c, input logic a);
        cap_pin = c;
        acc_in_pin = a;
    endtask
    task automatic glitch(input int ch);
        cap_pin[ch] = 1'b1;
        #5 cap_pin[ch] = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/tccpa_tb.sv ***
// Purpose: self-checking bench of the timer capture block
// Assumes: counter clock stays at clock/4 throughout
// Notes: seeded random pulse counts and widths
`timescale 1ns/1ps
`default_nettype none
`include "tccpa_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
 $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer_capture_compare_pulse_accum_tb_top;
    logic sys_clk, sys_rst, tfm, irq_req;
    tccpa_pkg::tccpa_req_t req;
    logic [15:0] rdata, v, c;
    logic [4:0] po, poe, pi;
    logic [2:0] cap;
    logic acc, aux;
    int err_total, n_checks, cyc, n;
    tccpa_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(req),
        .bus_rdata(rdata), .test_freeze_mode(tfm), .cap_pin(cap),
        .acc_in_pin(acc), .aux_clk_pin(aux), .port_pin_i(pi),
        .port_pin_o(po), .port_pin_oe(poe), .irq_req(irq_req));
    tccpa_pin_model pm (.sys_clk(sys_clk), .port_pin_o(po),
        .port_pin_oe(poe), .port_pin_i(pi), .cap_pin(cap),
        .acc_in_pin(acc), .aux_clk_pin(aux));
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // register write, one strobe cycle
    task automatic wr(input logic [4:0] i, input logic [15:0] d,
                      input logic [1:0] b = 2'b11);
        wait_n(1);
        req = '{wr: 1'b1, rd: 1'b0, be: b, idx: i, wdata: d};
        wait_n(1);
        req.wr = 1'b0;
    endtask
    // register read, data after the taking edge
    task automatic rd(input logic [4:0] i, output logic [15:0] d);
        wait_n(1);
        req = '{wr: 1'b0, rd: 1'b1, be: 2'b11, idx: i, wdata: 16'h0000};
        wait_n(1);
        req.rd = 1'b0;
        d = rdata;
    endtask
    initial begin
        req = '0;
        tfm = 1'b0;
        sys_rst = 1'b1;
        cyc = 0;
        err_total = 0;
        n_checks = 0;
        void'($urandom(32'h78F8A686));
        repeat (3) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        // reset values and unmapped place
        rd(`TCCPA_IDX_ACCUM, v);
        `CHK(v, 16'h0000)
        rd(5'h1F, v);
        `CHK(v, 16'h0000)
        rd(`TCCPA_IDX_COUNTER, c);
        wait_n(37);
        rd(`TCCPA_IDX_COUNTER, v);
        `CHK(v - c, 16'h000A)
        // captures: ch1 rise, ch2 fall, ch3 both
        wr(`TCCPA_IDX_EDGE, 16'h0039);
        pm.set_pins(3'h7, 1'b0);
        wait_n(10);
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0500)
        `CHK(irq_req, 1'b0)
        wr(`TCCPA_IDX_CHMASK, 16'h0100);
        wait_n(1);
        `CHK(irq_req, 1'b1)
        wr(`TCCPA_IDX_CHMASK, 16'h0000);
        rd(`TCCPA_IDX_CAP1, c);
        rd(`TCCPA_IDX_CAP3, v);
        `CHK(v, c)
        pm.set_pins(3'h0, 1'b0);
        wait_n(10);
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0700)
        rd(`TCCPA_IDX_CAP3, v);
        `CHK(v != c, 1'b1)
        rd(`TCCPA_IDX_CAP1, v);
        `CHK(v, c)
        // short glitch, then disabled edges, then random widths
        wr(`TCCPA_IDX_CHFLAG, 16'h0F1F);
        pm.glitch(0);
        wait_n(10);
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0000)
        wr(`TCCPA_IDX_EDGE, 16'h0000);
        pm.set_pins(3'h7, 1'b0);
        wait_n(6);
        pm.set_pins(3'h0, 1'b0);
        wait_n(10);
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0000)
        wr(`TCCPA_IDX_EDGE, 16'h0030);
        for (int k = 0; k < 4; k++) begin
            pm.set_pins(3'h4, 1'b0);
            wait_n(3 + $urandom % 4);
            pm.set_pins(3'h0, 1'b0);
            wait_n(10);
            rd(`TCCPA_IDX_CHFLAG, v);
            `CHK(v, 16'h0400)
            wr(`TCCPA_IDX_CHFLAG, 16'h0400);
        end
        // port latch, then compares with master override
        wr(`TCCPA_IDX_PORT, 16'h081F);
        wait_n(3);
        `CHK(po[3], 1'b1)
        `CHK(poe, 5'h1F)
        wr(`TCCPA_IDX_EDGE, 16'h2700);
        wr(`TCCPA_IDX_MASTER, 16'h0200);
        rd(`TCCPA_IDX_COUNTER, c);
        for (int k = 0; k < 4; k++) begin
            wr(`TCCPA_IDX_CMP1 + k[4:0], c + 16'd30);
        end
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0000)
        wait_n(120);
        `CHK(po[3:1], 3'b010)
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h000F)
        `CHK(irq_req, 1'b0)
        wr(`TCCPA_IDX_CHMASK, 16'h0002);
        wait_n(1);
        `CHK(irq_req, 1'b1)
        wr(`TCCPA_IDX_CHFLAG, 16'h000F);
        wait_n(1);
        `CHK(irq_req, 1'b0)
        // forced toggle on ch3, byte access
        wr(`TCCPA_IDX_FORCE, 16'h0400, 2'b10);
        wait_n(3);
        `CHK(po[2], 1'b0)
        rd(`TCCPA_IDX_FORCE, v);
        `CHK(v[15:8], 8'h00)
        rd(`TCCPA_IDX_CHFLAG, v);
        `CHK(v, 16'h0000)
        // shared register in capture and compare use
        wr(`TCCPA_IDX_ACCUM, 16'h0200);
        wr(`TCCPA_IDX_SHARED, 16'h1234);
        rd(`TCCPA_IDX_SHARED, v);
        `CHK(v, 16'h0000)
        tfm = 1'b1;
        wr(`TCCPA_IDX_SHARED, 16'h1234);
        tfm = 1'b0;
        rd(`TCCPA_IDX_SHARED, v);
        `CHK(v, 16'h1234)
        wr(`TCCPA_IDX_ACCUM, 16'h0000);
        wr(`TCCPA_IDX_SHARED, 16'hABCD);
        rd(`TCCPA_IDX_SHARED, v);
        `CHK(v, 16'hABCD)
        // event counting, both polarities
        wr(`TCCPA_IDX_MISC, 16'h00E0);
        for (int p = 1; p >= 0; p--) begin
            wr(`TCCPA_IDX_ACCUM, p ? 16'h1000 : 16'h0000);
            pm.set_pins(3'h0, 1'b1);
            wait_n(10);
            rd(`TCCPA_IDX_ACCUM, v);
            `CHK(v[15], 1'b1)
            `CHK(v[7:0], p[7:0])
            pm.set_pins(3'h0, 1'b0);
            wait_n(10);
            rd(`TCCPA_IDX_ACCUM, v);
            `CHK(v[7:0], 8'h01)
        end
        n = 1 + $urandom % 20;
        for (int k = 0; k < n; k++) begin
            pm.set_pins(3'h0, 1'b1);
            wait_n(3);
            pm.set_pins(3'h0, 1'b0);
            wait_n(3);
        end
        wait_n(8);
        rd(`TCCPA_IDX_ACCUM, v);
        `CHK(v[7:0], 8'(n + 1))
        rd(`TCCPA_IDX_MISC, v);
        `CHK(v[6], 1'b1)
        // wrap from all ones with its request
        wr(`TCCPA_IDX_ACCUM, 16'h00FF);
        wr(`TCCPA_IDX_MISC, 16'h80E0);
        pm.set_pins(3'h0, 1'b1);
        wait_n(4);
        pm.set_pins(3'h0, 1'b0);
        wait_n(10);
        rd(`TCCPA_IDX_ACCUM, v);
        `CHK(v[7:0], 8'h00)
        rd(`TCCPA_IDX_MISC, v);
        `CHK(v[7], 1'b1)
        `CHK(irq_req, 1'b1)
        wr(`TCCPA_IDX_MISC, 16'h40C0);
        wait_n(1);
        `CHK(irq_req, 1'b0)
        // gated by high level on clock/4, request at gate end
        wr(`TCCPA_IDX_ACCUM, 16'h3C00);
        wr(`TCCPA_IDX_MISC, 16'h40E0);
        pm.set_pins(3'h0, 1'b1);
        wait_n(40);
        `CHK(irq_req, 1'b0)
        pm.set_pins(3'h0, 1'b0);
        wait_n(10);
        `CHK(irq_req, 1'b1)
        rd(`TCCPA_IDX_ACCUM, v);
        `CHK(v[7:0] >= 8'd8 && v[7:0] <= 8'd12, 1'b1)
        finish_test();
    end
endmodule
`default_nettype wire

// *** verilog/tccpa_pkg.sv ***
// Purpose: shared types of the timer capture block
// Assumes: constants come from tccpa_regs.svh
// Notes: no imports; use tccpa_pkg::name
package tccpa_pkg;
    // pin action of compare channels 2..5
    typedef enum logic [1:0] {
        TCCPA_ACT_NONE = 2'b00,
        TCCPA_ACT_TOGGLE = 2'b01,
        TCCPA_ACT_LOW = 2'b10,
        TCCPA_ACT_HIGH = 2'b11
    } tccpa_act_t;
    // one register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] be;
        logic [4:0] idx;
        logic [15:0] wdata;
    } tccpa_req_t;
endpackage

// *** verilog/tccpa_regs.svh ***
// Purpose: offsets, field positions and counts of the timer capture block
// Assumes: word index addressing on a 16-bit register port
// Notes: values here are referenced by name, but the read mux also spells out indices as literals
`ifndef TCCPA_REGS_SVH
`define TCCPA_REGS_SVH
// word indices
`define TCCPA_IDX_COUNTER 5'h00
`define TCCPA_IDX_CAP1 5'h01
`define TCCPA_IDX_CAP3 5'h03
`define TCCPA_IDX_CMP1 5'h04
`define TCCPA_IDX_CMP4 5'h07
`define TCCPA_IDX_SHARED 5'h08
`define TCCPA_IDX_MASTER 5'h09
`define TCCPA_IDX_EDGE 5'h0A
`define TCCPA_IDX_CHMASK 5'h0B
`define TCCPA_IDX_CHFLAG 5'h0C
`define TCCPA_IDX_FORCE 5'h0D
`define TCCPA_IDX_ACCUM 5'h0E
`define TCCPA_IDX_MISC 5'h0F
`define TCCPA_IDX_PORT 5'h10
// accumulator control byte fields
`define TCCPA_ACC_PINST 7
`define TCCPA_ACC_AUXST 6
`define TCCPA_ACC_MODE 5
`define TCCPA_ACC_POL 4
`define TCCPA_ACC_CLKHI 3
`define TCCPA_ACC_CLKLO 2
`define TCCPA_ACC_FSEL 1
// misc mask (high byte) and misc flag (low byte) fields
`define TCCPA_MISC_OVF 7
`define TCCPA_MISC_EDGE 6
`define TCCPA_MISC_TOF 5
`define TCCPA_CPR_RESET 3'h0
`define TCCPA_NCH 5
`endif

// *** verilog/tccpa_top.sv ***
// Purpose: capture/compare channels and pulse accumulator of a timer
// Assumes: single 50 MHz sys_clk, async active-high sys_rst
// Notes: 16-bit register port with byte enables, word index address
// Behaviour
// R1: one 16-bit free-running counter from zero, prescaled, shared.
// R2: selected capture edge copies counter into latch and sets flag.
// R3: two edge bits pick rising, falling or both; zero disables.
// R4: capture channels are independent and may latch equal values.
// R5: capture flag always set; request only when its enable set.
// R6: capture inputs synchronised and filtered before latching.
// R7: pulses over two clocks captured, under one clock ignored.
// R8: capture reads never alter latch; word read coherent, bytes allowed.
// R9: capture repeats while flag set, latch holds newest value.
// R10: compare equal sets compare flag; request only when enabled.
// R11: master match sets or clears masked pins per action data.
// R12: master action wins over another match on the same pin.
// R13: force bit performs compare action at once without flags.
// R14: force bits self-clear, read zero, upper byte beside pwm byte.
// R15: select bit picks capture four or compare five; resets zero.
// R16: shared register is latch or compare; capture use rejects writes outside test/freeze mode.
// R17: 8-bit accumulator counts selected edges, at most clock/4.
// R18: gated mode counts chosen clock while input active; four sources.
// R19: sources include clock/512, aux pin and counter clock.
// R20: edge flag on selected edge, overflow flag on wrap to zero.
// R21: input request on counted edge, or gate end in gated mode.
// R22: mode bit picks event or gated; polarity bit picks edge/level.
// R23: control and count share one word, reset zero, two pin bits.
// R24: no false compare match while a compare value is written.
// R25: port writes latched; drive pin once compare control released.
// R26: compare channels 2..5 toggle, drive low, high or none.
// R27: flags stay until software clears; requests follow flags.
`include "tccpa_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tccpa_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire tccpa_pkg::tccpa_req_t bus_req,
    output logic [15:0] bus_rdata,
    input wire logic test_freeze_mode,
    input wire logic [2:0] cap_pin,
    input wire logic acc_in_pin,
    input wire logic aux_clk_pin,
    input wire logic [4:0] port_pin_i,
    output logic [4:0] port_pin_o,
    output logic [4:0] port_pin_oe,
    output logic irq_req
);
    logic [15:0] cnt_r, cap_r [0:2], cmp_r [0:3], shr_r;
    logic [4:0] amask_r, adata_r, cmp_flag_r, pdir_r, plat_r, pout_r;
    logic [3:0] cap_flag_r, cap_ien_r;
    logic [4:0] cmp_ien_r;
    logic [7:0] edge_r, act_r, pwm_r, acnt_r;
    logic [4:0] actl_r;
    logic [2:0] cpr_r;
    logic ovf_ien_r, edg_ien_r, ovf_flag_r, edg_flag_r, tof_r;
    logic [8:0] div_r;
    logic [5:0] s1_r, s2_r, s3_r, flt_r, fltd_r;
    logic cnt_new_r;
    logic [4:0] pin_m_r, pin_s_r;

    // request decode
    wire wr = bus_req.wr;
    wire [4:0] idx = bus_req.idx;
    wire [15:0] wd = bus_req.wdata;
    wire bh = bus_req.be[1];
    wire bl = bus_req.be[0];
    wire wr_cnt = wr && idx == `TCCPA_IDX_COUNTER && test_freeze_mode;
    wire wr_shr = wr && idx == `TCCPA_IDX_SHARED;
    wire wr_force = wr && idx == `TCCPA_IDX_FORCE && bh;
    wire wr_flag = wr && idx == `TCCPA_IDX_CHFLAG;
    wire wr_misc = wr && idx == `TCCPA_IDX_MISC;
    wire wr_acc = wr && idx == `TCCPA_IDX_ACCUM;
    wire fsel = actl_r[`TCCPA_ACC_FSEL - 1];

    // byte-lane merge of a write
    function automatic logic [15:0] merge(input logic [15:0] o);
        merge = {bh ? wd[15:8] : o[15:8], bl ? wd[7:0] : o[7:0]};
    endfunction

    // prescaler taps: k selects clock / 2^(k+2), 7 selects aux pin
    logic [6:0] taps;
    genvar k;
    generate
        for (k = 0; k < 7; k++) begin : g_tap
            assign taps[k] = &div_r[k + 1:0];
        end
    endgenerate
    wire tick512 = &div_r;
    wire [5:0] rise = flt_r & ~fltd_r;
    wire [5:0] fall = ~flt_r & fltd_r;
    wire cc_tick = (cpr_r == 3'h7) ? rise[5] : taps[cpr_r];

    // prescaler divider, free running
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) div_r <= 9'h000;
        else div_r <= div_r + 9'h001;
    end

    // R1: main counter
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 16'h0000;
            cnt_new_r <= 1'b0;
        end else begin
            cnt_new_r <= cc_tick | wr_cnt;
            if (wr_cnt) cnt_r <= merge(cnt_r);
            else if (cc_tick) cnt_r <= cnt_r + 16'h0001;
        end
    end

    // R6: two-flop sync then filter; R7: level needs two equal samples
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {s1_r, s2_r, s3_r} <= 18'h00000;
            {flt_r, fltd_r, pin_m_r, pin_s_r} <= 22'h000000;
        end else begin
            s1_r <= {aux_clk_pin, acc_in_pin, port_pin_i[4], cap_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= (flt_r & (s2_r ^ s3_r)) | (s2_r & s3_r);
            fltd_r <= flt_r;
            pin_m_r <= port_pin_i;
            pin_s_r <= pin_m_r;
        end
    end

    // R3: edge select per capture channel, channel 4 only in capture use
    logic [3:0] cap_hit;
    generate
        for (k = 0; k < 4; k++) begin : g_cap
            assign cap_hit[k] = ((edge_r[2*k] & rise[k])
                | (edge_r[2*k+1] & fall[k])) & (k != 3 || fsel);
        end
    endgenerate

    // R2: capture latches; R4: channels independent; R9: always overwrite
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_r[0] <= 16'h0000;
            cap_r[1] <= 16'h0000;
            cap_r[2] <= 16'h0000;
        end else begin
            for (int i = 0; i < 3; i++)
                if (cap_hit[i]) cap_r[i] <= cnt_r;
        end
    end

    // R24: match only on a fresh count and never during a value write
    logic [4:0] cmp_hit, cmp_wr;
    logic [15:0] cval [0:4];
    generate
        for (k = 0; k < 4; k++) begin : g_cmp
            assign cval[k] = cmp_r[k];
            assign cmp_wr[k] = wr && idx == `TCCPA_IDX_CMP1 + 5'(k);
        end
    endgenerate
    assign cval[4] = shr_r;
    assign cmp_wr[4] = wr_shr;
    generate
        for (k = 0; k < 5; k++) begin : g_hit
            assign cmp_hit[k] = cnt_new_r && cnt_r == cval[k]
                && !cmp_wr[k] && (k != 4 || !fsel);
        end
    endgenerate

    // R13: forced channels act like matches; R14: force bits self-clear
    wire [4:0] frc = wr_force ? wd[12:8] : 5'h00;
    wire [4:0] fire = cmp_hit | (frc & {~fsel, 4'hF});

    // R26: per-channel action of channels 2..5 on their own pin
    logic [4:0] pnxt;
    always_comb begin
        pnxt = pout_r;
        for (int i = 1; i < 5; i++) begin
            if (fire[i]) begin
                case (tccpa_pkg::tccpa_act_t'(act_r[2*i-1 -: 2]))
                    tccpa_pkg::TCCPA_ACT_TOGGLE: pnxt[i] = ~pout_r[i];
                    tccpa_pkg::TCCPA_ACT_LOW: pnxt[i] = 1'b0;
                    tccpa_pkg::TCCPA_ACT_HIGH: pnxt[i] = 1'b1;
                    default: pnxt[i] = pout_r[i];
                endcase
            end
        end
        // R11: master action on masked pins; R12: applied last, wins
        if (fire[0]) pnxt = (pnxt & ~amask_r) | (adata_r & amask_r);
    end

    // R25: pins under compare control ignore the port latch
    logic [4:0] ctl;
    always_comb begin
        ctl = amask_r;
        for (int i = 1; i < 5; i++)
            ctl[i] = ctl[i] | (act_r[2*i-1 -: 2] != 2'b00);
        ctl[4] = ctl[4] & ~fsel;
    end

    // compare-driven pin state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) pout_r <= 5'h00;
        else pout_r <= pnxt;
    end

    // R25: port drive and direction, registered
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_pin_o <= 5'h00;
            port_pin_oe <= 5'h00;
        end else begin
            port_pin_o <= (pnxt & ctl) | (plat_r & ~ctl);
            port_pin_oe <= pdir_r;
        end
    end

    // R18: gated clock sources; R19: /512, aux pin, counter clock
    logic gclk;
    always_comb begin
        case (actl_r[`TCCPA_ACC_CLKHI - 1 -: 2])
            2'b00: gclk = tick512;
            2'b01: gclk = rise[5];
            2'b10: gclk = cc_tick;
            default: gclk = taps[0];
        endcase
    end

    // R22: mode and polarity; R17: event edges rate-limited by filter
    wire amode = actl_r[`TCCPA_ACC_MODE - 1];
    wire apol = actl_r[`TCCPA_ACC_POL - 1];
    wire pai_act = flt_r[4] ~^ apol;
    wire pai_edge = apol ? rise[4] : fall[4];
    wire gate_end = apol ? fall[4] : rise[4];
    wire acc_inc = amode ? (gclk & pai_act) : pai_edge;
    // R21: event edge in event mode, gate end in gated mode
    wire acc_evt = amode ? gate_end : pai_edge;
    wire acc_wrap = acc_inc && acnt_r == 8'hFF;

    // R23: accumulator count, word shared with control byte
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) acnt_r <= 8'h00;
        else if (wr_acc && bl) acnt_r <= wd[7:0];
        else if (acc_inc) acnt_r <= acnt_r + 8'h01;
    end

    // R27: flags set by hardware, write one clears; set wins over clear
    wire [15:0] fw = wr_flag ? ({{8{bh}}, {8{bl}}} & wd) : 16'h0000;
    wire [7:0] mw = (wr_misc && bl) ? wd[7:0] : 8'h00;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_flag_r <= 5'h00;
            cap_flag_r <= 4'h0;
            ovf_flag_r <= 1'b0;
            edg_flag_r <= 1'b0;
            tof_r <= 1'b0;
        end else begin
            // R5: capture flag; R10: compare flag, forces excluded
            cap_flag_r <= (cap_flag_r & ~fw[11:8]) | cap_hit;
            cmp_flag_r <= (cmp_flag_r & ~fw[4:0]) | cmp_hit;
            // R20: accumulator edge and overflow flags
            edg_flag_r <= (edg_flag_r & ~mw[`TCCPA_MISC_EDGE]) | acc_evt;
            ovf_flag_r <= (ovf_flag_r & ~mw[`TCCPA_MISC_OVF]) | acc_wrap;
            tof_r <= (tof_r & ~mw[`TCCPA_MISC_TOF])
                | (cc_tick && cnt_r == 16'hFFFF && !wr_cnt);
        end
    end

    // R5: R10: R21: requests follow flags gated by enables
    assign irq_req = |(cap_flag_r & cap_ien_r) | |(cmp_flag_r & cmp_ien_r)
        | (ovf_flag_r & ovf_ien_r) | (edg_flag_r & edg_ien_r);

    // software configuration registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) cmp_r[i] <= 16'h0000;
            {amask_r, adata_r, pdir_r, plat_r} <= 20'h00000;
            {edge_r, act_r, pwm_r} <= 24'h000000;
            {cap_ien_r, cmp_ien_r, ovf_ien_r, edg_ien_r} <= 11'h000;
            actl_r <= 5'h00;
            cpr_r <= `TCCPA_CPR_RESET;
        end else if (wr) begin
            case (idx)
                `TCCPA_IDX_MASTER: {amask_r, adata_r} <=
                    {bh ? wd[12:8] : amask_r, bl ? wd[4:0] : adata_r};
                `TCCPA_IDX_EDGE: {act_r, edge_r} <= merge({act_r, edge_r});
                `TCCPA_IDX_CHMASK: {cap_ien_r, cmp_ien_r} <=
                    {bh ? wd[11:8] : cap_ien_r, bl ? wd[4:0] : cmp_ien_r};
                // R14: only the pwm byte stores
                `TCCPA_IDX_FORCE: if (bl) pwm_r <= wd[7:0];
                // R15: select bit in accumulator control
                `TCCPA_IDX_ACCUM: if (bh) actl_r <= wd[13:9];
                `TCCPA_IDX_MISC: if (bh) begin
                    ovf_ien_r <= wd[8 + `TCCPA_MISC_OVF];
                    edg_ien_r <= wd[8 + `TCCPA_MISC_EDGE];
                    cpr_r <= wd[10:8];
                end
                `TCCPA_IDX_PORT: {plat_r, pdir_r} <=
                    {bh ? wd[12:8] : plat_r, bl ? wd[4:0] : pdir_r};
                default: begin
                    if (idx >= `TCCPA_IDX_CMP1 && idx <= `TCCPA_IDX_CMP4)
                        cmp_r[idx[1:0]] <= merge(cmp_r[idx[1:0]]);
                end
            endcase
        end
    end

    // R16: shared register writable as compare, or in test/freeze mode
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) shr_r <= 16'h0000;
        else if (cap_hit[3]) shr_r <= cnt_r;
        else if (wr_shr && (!fsel || test_freeze_mode)) shr_r <= merge(shr_r);
    end

    // R8: read mux, no side effects; R14: force bits read zero
    logic [15:0] rmux;
    always_comb begin
        case (idx)
            `TCCPA_IDX_COUNTER: rmux = cnt_r;
            5'h01, 5'h02, `TCCPA_IDX_CAP3: rmux = cap_r[idx[1:0] - 2'h1];
            5'h04, 5'h05, 5'h06, `TCCPA_IDX_CMP4: rmux = cmp_r[idx[1:0]];
            `TCCPA_IDX_SHARED: rmux = shr_r;
            `TCCPA_IDX_MASTER: rmux = {3'h0, amask_r, 3'h0, adata_r};
            `TCCPA_IDX_EDGE: rmux = {act_r, edge_r};
            `TCCPA_IDX_CHMASK: rmux = {4'h0, cap_ien_r, 3'h0, cmp_ien_r};
            `TCCPA_IDX_CHFLAG: rmux = {4'h0, cap_flag_r, 3'h0, cmp_flag_r};
            `TCCPA_IDX_FORCE: rmux = {8'h00, pwm_r};
            // R23: live pin levels in the top control bits
            `TCCPA_IDX_ACCUM: rmux = {flt_r[4], flt_r[5], actl_r, 1'b0,
                acnt_r};
            `TCCPA_IDX_MISC: rmux = {ovf_ien_r, edg_ien_r, 3'h0, cpr_r,
                ovf_flag_r, edg_flag_r, tof_r, 5'h00};
            `TCCPA_IDX_PORT: rmux = {3'h0, pin_s_r, 3'h0, pdir_r};
            default: rmux = 16'h0000;
        endcase
    end

    // registered read data
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) bus_rdata <= 16'h0000;
        else if (bus_req.rd) bus_rdata <= rmux;
    end

    // checks
    sequence s_ovf_wrap;
        acc_wrap && !(wr_acc && bl);
    endsequence
    a_counter_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cc_tick && !wr_cnt |=> cnt_r == $past(cnt_r) + 16'h0001) // R1
        else $error("counter did not step");
    a_capture_value: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cap_hit[0] |=> cap_r[0] == $past(cnt_r) && cap_flag_r[0]) // R2
        else $error("capture latch wrong");
    a_capture_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
        edge_r[1:0] == 2'b00 |-> !cap_hit[0]) // R3
        else $error("disabled capture fired");
    a_capture_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cap_flag_r[2] && cap_hit[2] |=> cap_r[2] == $past(cnt_r)) // R9
        else $error("capture lost while flagged");
    a_compare_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmp_hit[1] |=> cmp_flag_r[1]) // R10
        else $error("compare flag not set");
    a_master_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fire[0] && fire[1] && amask_r[1]
        |=> pout_r[1] == $past(adata_r[1])) // R12
        else $error("master action lost");
    a_force_noflag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_force && cmp_hit == 5'h00
        |=> cmp_flag_r == ($past(cmp_flag_r) & ~$past(fw[4:0]))) // R13
        else $error("force set a flag");
    a_accum_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_ovf_wrap |=> acnt_r == 8'h00 && ovf_flag_r) // R20
        else $error("overflow not flagged");
endmodule
`default_nettype wire
